// file: verilog/acr_pkg.sv
// acr_pkg: shared constants and types of the converter serial readout block
package acr_pkg;
	// ==========================================================
	// frame layout
	localparam int FRAME_BITS = 32;
	localparam int DATA_BITS = 31;
	localparam int CFG_BITS = 13;
	localparam int CHAN_BITS = 8;
	localparam int SPEED_BITS = 5;
	localparam int CHAN_LSB = 5;
	localparam int RATE_BIT = 0;
	localparam int MUX_FALL = 14;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [4:0] SPEED_RESET = 5'h1E;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int DONE_TEST_DELAY_NS = 500;
	localparam int DLY_CYC = (DONE_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYC = 4;
	// ==========================================================
	// states
	typedef enum logic [1:0] {
		ST_CONV = 2'b00,
		ST_SLEEP = 2'b01,
		ST_SHIFT = 2'b10
	} acr_state_t;
endpackage : acr_pkg

// file: verilog/acr_readout.sv
// acr_readout: serial readout and configuration logic of the converter
`timescale 1ns/1ps
// Behaviour
// - data output released while chip select high
// - chip select low shows inverted done flag
// - conversion end always enters sleep
// - sleep holds result until first clock rise
// - output changes on falling, host samples rising
// - external: 32nd falling starts conversion, output and busy high
// - chip select rise mid frame aborts, converts
// - abort before 13th rise keeps old settings
// - two-wire: result loaded as busy falls
// - two-wire: 32nd falling raises output, busy, converts
// - internal: chip select low in sleep drives clock low
// - busy high converting, low until read
// - internal: clock starts 500ns after ready
// - chip select rise before delay keeps sleeping
// - internal: 32 rises, then high and convert
// - internal: abort after first rise converts
// - last speed bit selects double rate
// - normal rate: mux switches at 14th falling
module acr_readout import acr_pkg::*; #(
	parameter int SCK_HALF = SCK_HALF_CYC,
	parameter int DLY = DLY_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins from the host
	input wire logic cs_n,
	input wire logic sck_in,
	input wire logic sdi,
	input wire logic clock_source_select,
	// pins to the host
	output logic sck_out,
	output logic sck_oe,
	output logic sdo_out,
	output logic sdo_oe,
	output logic busy,
	// converter core side
	input wire logic res_valid,
	input wire logic [DATA_BITS-1:0] res_data,
	output logic res_ready,
	output logic conv_start,
	// applied settings
	output logic [SPEED_BITS-1:0] speed_cfg,
	output logic double_rate_select,
	output logic [CHAN_BITS-1:0] mux_channel
);
	// ==========================================================
	// input synchronisers
	logic [1:0] cs_sy_reg, sck_sy_reg, sdi_sy_reg, sel_sy_reg;
	logic cs_d_reg, sck_d_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_sy_reg <= 2'h3;
			sck_sy_reg <= 2'h0;
			sdi_sy_reg <= 2'h0;
			sel_sy_reg <= 2'h0;
			cs_d_reg <= 1'b1;
			sck_d_reg <= 1'b0;
		end else begin
			cs_sy_reg <= {cs_sy_reg[0], cs_n};
			sck_sy_reg <= {sck_sy_reg[0], sck_in};
			sdi_sy_reg <= {sdi_sy_reg[0], sdi};
			sel_sy_reg <= {sel_sy_reg[0], clock_source_select};
			cs_d_reg <= cs_sy_reg[1];
			sck_d_reg <= sck_sy_reg[1];
		end
	end
	wire cs_s = cs_sy_reg[1];
	wire int_mode = sel_sy_reg[1];
	wire cs_rise = cs_s & ~cs_d_reg;
	wire ext_rise = ~int_mode & sck_sy_reg[1] & ~sck_d_reg;
	wire ext_fall = ~int_mode & ~sck_sy_reg[1] & sck_d_reg;

	// ==========================================================
	// result buffer, two entries; the core stalls while it is full
	logic [DATA_BITS-1:0] buf_mem [0:1];
	logic buf_wr_reg, buf_rd_reg;
	logic [1:0] buf_cnt_reg;
	acr_state_t state_reg;
	wire buf_valid = buf_cnt_reg != 2'h0;
	wire push = res_valid & res_ready;
	// a conversion lasts at least two cycles, so the high flag is always seen after a frame
	wire load = (state_reg == ST_CONV) & buf_valid & ~conv_start;
	wire [1:0] buf_cnt_next = 2'(buf_cnt_reg + {1'b0, push} - {1'b0, load});
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_wr_reg <= 1'b0;
			buf_rd_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
			res_ready <= 1'b1;
		end else begin
			buf_wr_reg <= buf_wr_reg ^ push;
			buf_rd_reg <= buf_rd_reg ^ load;
			buf_cnt_reg <= buf_cnt_next;
			res_ready <= buf_cnt_next != 2'h2;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			buf_mem[buf_wr_reg] <= res_data;
		end
	end

	// ==========================================================
	// edge generation and frame control
	logic [7:0] tmr_reg, div_reg;
	logic [5:0] rcnt_reg, fcnt_reg;
	logic [FRAME_BITS-1:0] sh_reg;
	logic [CFG_BITS-1:0] in_sh_reg;
	logic [CHAN_BITS-1:0] chan_reg;
	wire asleep_sel = (state_reg == ST_SLEEP) & ~cs_s;
	wire in_shift = state_reg == ST_SHIFT;
	// the delay restarts whenever chip select goes high, so a short poll never wakes it
	wire tmr_run = asleep_sel & int_mode;
	wire tmr_done = tmr_run & (tmr_reg == 8'(DLY - 1));
	wire div_done = in_shift & int_mode & (div_reg == 8'(SCK_HALF - 1));
	wire int_rise = tmr_done | (div_done & ~sck_out);
	wire int_fall = div_done & sck_out;
	wire rise_ev = int_rise | (ext_rise & (asleep_sel | (in_shift & ~cs_s)));
	wire fall_ev = int_fall | (ext_fall & in_shift & ~cs_s);
	wire abort = cs_rise & in_shift;
	wire int_end = int_mode & rise_ev & (rcnt_reg == 6'(FRAME_BITS - 1));
	wire ext_end = ~int_mode & fall_ev & (fcnt_reg == 6'(FRAME_BITS - 1));
	wire start = int_end | ext_end | abort;
	wire [CFG_BITS-1:0] in_word = {in_sh_reg[CFG_BITS-2:0], sdi_sy_reg[1]};
	wire commit = rise_ev & ~abort & (rcnt_reg == 6'(CFG_BITS - 1));
	wire [4:0] new_speed = in_word[4:0];
	wire [4:0] speed_next = (new_speed[4:1] == 4'h0) ? {speed_cfg[4:1], new_speed[0]} : new_speed;
	wire mux_1x = fall_ev & (fcnt_reg == 6'(MUX_FALL - 1)) & ~double_rate_select;
	acr_state_t st_next;
	assign st_next = start ? ST_CONV :
		load ? ST_SLEEP :
		(rise_ev & ~in_shift) ? ST_SHIFT : state_reg;
	wire [FRAME_BITS-1:0] sh_next = load ? {1'b0, buf_mem[buf_rd_reg]} :
		fall_ev ? {sh_reg[FRAME_BITS-2:0], 1'b1} : sh_reg;
	wire sck_next = (st_next == ST_CONV) | ((st_next == ST_SLEEP) & cs_s) |
		((st_next == ST_SHIFT) & (tmr_done | (div_done ? ~sck_out : sck_out)));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_CONV;
			tmr_reg <= 8'h00;
			div_reg <= 8'h00;
			rcnt_reg <= 6'h00;
			fcnt_reg <= 6'h00;
			sh_reg <= 32'hFFFFFFFF;
			in_sh_reg <= 13'h0000;
		end else begin
			state_reg <= st_next;
			tmr_reg <= tmr_run ? 8'(tmr_reg + 8'h01) : 8'h00;
			div_reg <= (~in_shift | div_done) ? 8'h00 : 8'(div_reg + 8'h01);
			rcnt_reg <= rise_ev ? 6'(rcnt_reg + 6'h01) : (in_shift ? rcnt_reg : 6'h00);
			fcnt_reg <= fall_ev ? 6'(fcnt_reg + 6'h01) : (in_shift ? fcnt_reg : 6'h00);
			sh_reg <= sh_next;
			if (rise_ev) begin
				in_sh_reg <= in_word;
			end
		end
	end

	// ==========================================================
	// pin and settings outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdo_out <= 1'b1;
			sdo_oe <= 1'b0;
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
			busy <= 1'b1;
			conv_start <= 1'b1;
			speed_cfg <= SPEED_RESET;
			chan_reg <= CFG_RESET;
			mux_channel <= CFG_RESET;
		end else begin
			// the last bit stands through the 32nd rise; the flag goes high a cycle later
			sdo_out <= ((st_next == ST_CONV) & ~int_end) | sh_next[FRAME_BITS-1];
			sdo_oe <= ~cs_s;
			sck_out <= sck_next;
			sck_oe <= int_mode;
			busy <= st_next == ST_CONV;
			conv_start <= start;
			if (commit) begin
				speed_cfg <= speed_next;
				chan_reg <= in_word[CHAN_LSB+CHAN_BITS-1:CHAN_LSB];
			end
			// double rate moves the mux as each result is taken, normal rate mid frame
			if (mux_1x) begin
				mux_channel <= chan_reg;
			end else if (start | (load & double_rate_select)) begin
				mux_channel <= chan_reg;
			end
		end
	end
	assign double_rate_select = speed_cfg[RATE_BIT];

	// ==========================================================
	// assertions
	property p_release;
		@(posedge clk) disable iff (rst) cs_s |=> !sdo_oe;
	endproperty
	a_release: assert property (p_release) else $error("sdo driven with cs high");
	property p_flag;
		@(posedge clk) disable iff (rst)
			(!cs_s && st_next == ST_CONV && !int_end) |=> sdo_oe && sdo_out;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not high in conversion");
	property p_sleep;
		@(posedge clk) disable iff (rst) load |=> state_reg == ST_SLEEP && !busy && !sdo_out;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep after conversion");
	property p_ext_end;
		@(posedge clk) disable iff (rst) ext_end |=> busy && sdo_out && conv_start ##1 !conv_start;
	endproperty
	a_ext_end: assert property (p_ext_end) else $error("frame end wrong");
	property p_abort;
		@(posedge clk) disable iff (rst) abort |=> busy && sdo_out && state_reg == ST_CONV;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not convert");
	property p_keep;
		@(posedge clk) disable iff (rst) (abort && rcnt_reg < 6'(CFG_BITS)) |=> $stable(speed_cfg);
	endproperty
	a_keep: assert property (p_keep) else $error("settings changed on early abort");
	property p_delay;
		@(posedge clk) disable iff (rst)
			(int_mode && $rose(state_reg == ST_SHIFT)) |-> $past(tmr_reg) == 8'(DLY - 1);
	endproperty
	a_delay: assert property (p_delay) else $error("clock start delay wrong");
	property p_int_end;
		@(posedge clk) disable iff (rst) int_end |=> sck_out && busy ##1 sck_out && busy;
	endproperty
	a_int_end: assert property (p_int_end) else $error("clock not held high");
	property p_busy;
		@(posedge clk) disable iff (rst) (state_reg == ST_SHIFT && !start) |=> !busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy high during readout");
	// ==========================================================
	// link-side assertions
	property p_flag_low;
		@(posedge clk) disable iff (rst) (load && !cs_s) |=> sdo_oe && !sdo_out;
	endproperty
	a_flag_low: assert property (p_flag_low) else $error("flag not low in sleep");
	property p_hold;
		@(posedge clk) disable iff (rst)
			(state_reg == ST_SLEEP && !rise_ev) |=> state_reg == ST_SLEEP && $stable(sh_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("sleep left without clock rise");
	property p_fall_only;
		@(posedge clk) disable iff (rst) (in_shift && !fall_ev && !start) |=> $stable(sdo_out);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("sdo moved off a fall");
	property p_load;
		@(posedge clk) disable iff (rst)
			load |=> !sh_reg[FRAME_BITS-1] && sh_reg[FRAME_BITS-2:0] == buf_mem[~buf_rd_reg];
	endproperty
	a_load: assert property (p_load) else $error("result not loaded");
	property p_two_end;
		@(posedge clk) disable iff (rst) ext_end |=> busy && sdo_out && state_reg == ST_CONV;
	endproperty
	a_two_end: assert property (p_two_end) else $error("no conversion after 32nd fall");
	property p_sck_low;
		@(posedge clk) disable iff (rst)
			(int_mode && state_reg == ST_SLEEP && !cs_s && !tmr_done) |=> !sck_out;
	endproperty
	a_sck_low: assert property (p_sck_low) else $error("sck not low while polled");
	property p_stay;
		@(posedge clk) disable iff (rst)
			(int_mode && state_reg == ST_SLEEP && cs_s) |=> state_reg == ST_SLEEP && tmr_reg == 8'h00;
	endproperty
	a_stay: assert property (p_stay) else $error("woke with cs high");
	property p_last;
		@(posedge clk) disable iff (rst)
			int_end |=> sdo_out == $past(sh_reg[FRAME_BITS-1]) ##1 sdo_out && busy;
	endproperty
	a_last: assert property (p_last) else $error("last bit or end flag wrong");
	property p_int_abort;
		@(posedge clk) disable iff (rst)
			(int_mode && abort) |=> busy && sck_out && state_reg == ST_CONV;
	endproperty
	a_int_abort: assert property (p_int_abort) else $error("internal abort wrong");
	property p_rate;
		@(posedge clk) disable iff (rst) commit |=> double_rate_select == $past(in_word[RATE_BIT]);
	endproperty
	a_rate: assert property (p_rate) else $error("rate select not taken");
	property p_mux;
		@(posedge clk) disable iff (rst)
			(fall_ev && fcnt_reg == 6'(MUX_FALL - 1) && !double_rate_select) |=> mux_channel == chan_reg;
	endproperty
	a_mux: assert property (p_mux) else $error("mux not switched at 14th fall");
	property p_sample;
		@(posedge clk) disable iff (rst) rise_ev |=> in_sh_reg[0] == $past(sdi_sy_reg[1]);
	endproperty
	a_sample: assert property (p_sample) else $error("input bit not taken");
	property p_chan;
		@(posedge clk) disable iff (rst)
			commit |=> chan_reg == $past(in_word[CHAN_LSB+CHAN_BITS-1:CHAN_LSB]);
	endproperty
	a_chan: assert property (p_chan) else $error("channel not taken");
	c_ext_frame: cover property (@(posedge clk) disable iff (rst) ext_end);
	c_int_frame: cover property (@(posedge clk) disable iff (rst) int_end);
	c_abort: cover property (@(posedge clk) disable iff (rst) abort && rcnt_reg > 6'h0D);
	c_full: cover property (@(posedge clk) disable iff (rst) !res_ready);
	c_poll: cover property (@(posedge clk) disable iff (rst) int_mode && cs_rise && !in_shift);
endmodule : acr_readout

// file: test/acr_host.sv
// acr_host: host controller model driving chip select and the serial clock
`timescale 1ns/1ps
module acr_host (
	// clock
	input wire logic clk,
	// pins to the device
	output logic cs_n,
	output logic sck_in,
	output logic sdi,
	// pins from the device
	input wire logic sck_out,
	input wire logic sdo_out,
	// captured frame
	output logic [31:0] rx_word,
	output logic rx_done
);
	// ==========================================
	// idle pins
	initial begin
		cs_n = 1'b1;
		sck_in = 1'b0;
		sdi = 1'b0;
		rx_done = 1'b0;
		rx_word = 32'h0;
	end
	// ==========================================
	// frame end; a released sdi shows the inverse so a stale bit is never reused
	task automatic finish_frame(input logic full);
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi;
		rx_done = full;
		@(negedge clk);
		rx_done = 1'b0;
	endtask : finish_frame
	// ==========================================
	// host clock, 8 cycles a bit; nfall below 32 aborts after that fall
	task automatic ext_frame(input logic [12:0] cfg, input int nfall);
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = 0; i < nfall; i++) begin
			sdi = (i < 13) ? cfg[12-i] : ~sdi;
			repeat (4) @(negedge clk);
			sck_in = 1'b1;
			rx_word = {rx_word[30:0], sdo_out};
			repeat (4) @(negedge clk);
			sck_in = 1'b0;
		end
		finish_frame(nfall >= 32);
	endtask : ext_frame
	// ==========================================
	// device clock; max_t bounds how long chip select stays low
	task automatic int_frame(input logic lvl, input int max_t, output int lat);
		int n;
		logic p;
		n = 0;
		lat = 0;
		p = 1'b1;
		@(negedge clk);
		cs_n = 1'b0;
		sdi = lvl;
		for (int t = 0; t < max_t && n < 32; t++) begin
			@(negedge clk);
			if (sck_out && !p) begin
				if (n == 0)
					lat = t;
				rx_word = {rx_word[30:0], sdo_out};
				n++;
			end
			p = sck_out;
		end
		finish_frame(n == 32);
	endtask : int_frame
endmodule : acr_host

// file: test/tb.sv
// tb: self-checking bench of the converter serial readout block
`timescale 1ns/1ps
module tb import acr_pkg::*;;
	logic clk, rst, cs_n, sck_in, sdi, css, sck_out, sck_oe, sdo_out, sdo_oe, busy;
	logic res_valid, res_ready, conv_start, double_rate_select, rx_done;
	logic [30:0] res_data;
	logic [4:0] speed_cfg;
	logic [7:0] mux_channel;
	logic [31:0] rx_word;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int n_checks = 0;
	int n_starts = 0;
	logic busy_seen = 1'b0;
	// a released sdo shows the inverse, so sampling it undriven is caught
	wire sdo_pin;
	assign sdo_pin = sdo_oe ? sdo_out : ~sdo_out;
	acr_readout i_acr_readout (.clk, .rst, .cs_n, .sck_in, .sdi, .clock_source_select(css),
		.sck_out, .sck_oe, .sdo_out, .sdo_oe, .busy, .res_valid, .res_data, .res_ready,
		.conv_start, .speed_cfg, .double_rate_select, .mux_channel);
	acr_host i_acr_host (.clk, .cs_n, .sck_in, .sdi, .sck_out, .sdo_out(sdo_pin), .rx_word,
		.rx_done);
	always @(negedge clk) begin
		if (busy === 1'b1)
			busy_seen = 1'b1;
		if (conv_start === 1'b1)
			n_starts++;
	end
	// ==========================================
	// checking
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	always @(posedge rx_done) cmp(rx_word, exp_q.pop_front());
	// ==========================================
	// drivers
	task automatic push();
		res_data = 31'($urandom);
		res_valid = 1'b1;
		exp_q.push_back({1'b0, res_data});
		@(negedge clk);
		res_valid = 1'b0;
		@(negedge clk);
	endtask : push
	// busy may be high for two cycles only, so a rise is latched in busy_seen
	task automatic wait_busy(input logic v);
		for (int t = 0; t < 300 && (v ? busy_seen !== 1'b1 : busy !== 1'b0); t++)
			@(negedge clk);
		cmp(v ? busy_seen : busy, v);
		busy_seen = 1'b0;
	endtask : wait_busy
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
	// ==========================================
	// scenarios
	initial begin
		int n, lat;
		logic [12:0] c1;
		rst = 1'b1;
		css = 1'b0;
		res_valid = 1'b0;
		res_data = 31'h0;
		void'($urandom(32'hAB2C269F));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		cmp(sdo_oe, 1'b0);
		cmp(sck_oe, 1'b0);
		n = 0;
		while (res_ready === 1'b1 && n < 4) begin
			push();
			n++;
		end
		cmp(res_ready, 1'b0);
		wait_busy(1'b0);
		n_starts = 0;
		c1 = {8'($urandom), 5'($urandom_range(2, 31))};
		i_acr_host.ext_frame(c1, 32);
		wait_busy(1'b1);
		cmp({mux_channel, speed_cfg, double_rate_select}, {c1, c1[0]});
		wait_busy(1'b0);
		i_acr_host.ext_frame(~c1, 8);
		void'(exp_q.pop_front());
		wait_busy(1'b1);
		cmp({mux_channel, speed_cfg}, c1);
		css = 1'b1;
		while (exp_q.size() > 0) begin
			wait_busy(1'b0);
			i_acr_host.int_frame(1'b1, 4000, lat);
			cmp(lat >= DLY_CYC && lat <= DLY_CYC + 6, 1'b1);
			wait_busy(1'b1);
			cmp(sck_oe, 1'b1);
			cmp({mux_channel, speed_cfg}, 13'h1FFF);
		end
		repeat (40) @(negedge clk);
		cmp({busy, res_ready}, 2'b11);
		push();
		wait_busy(1'b0);
		i_acr_host.int_frame(1'b0, 5, lat);
		repeat (40) @(negedge clk);
		cmp(busy, 1'b0);
		i_acr_host.int_frame(1'b0, 4000, lat);
		wait_busy(1'b1);
		cmp({mux_channel, speed_cfg}, 13'h001E);
		push();
		wait_busy(1'b0);
		i_acr_host.int_frame(1'b1, 60, lat);
		void'(exp_q.pop_front());
		wait_busy(1'b1);
		cmp({mux_channel, speed_cfg}, 13'h001E);
		cmp(n_starts, 32'd5);
		conclude();
	end
endmodule : tb
